// ==== include/scs_pkg.sv ====
// constants and types shared by the system clock control block
package scs_pkg;
	// host command bytes (first byte of a three byte command frame)
	localparam logic [7:0] SELECT_EXTERNAL_REF_CMD = 8'h44;
	localparam logic [7:0] SELECT_INTERNAL_REF_CMD = 8'h48;
	localparam logic [7:0] SYSCLK_HIGH_FREQ_CMD = 8'h62;
	localparam logic [7:0] SYSCLK_LOW_FREQ_CMD = 8'h61;
	// frame layout: two prefix bits then a six bit code
	localparam int PREFIX_MSB = 7;
	localparam int PREFIX_LSB = 6;
	localparam int CODE_MSB = 5;
	localparam logic [1:0] PREFIX_CMD = 2'h1;
	localparam logic [1:0] PREFIX_READ = 2'h0;
	localparam logic [1:0] FRAME_LAST_BYTE = 2'h2;
	// reference source encoding
	typedef enum logic [1:0] {
		SCS_REF_INTERNAL = 2'h0,
		SCS_REF_CRYSTAL = 2'h1,
		SCS_REF_SQUARE = 2'h2
	} scs_ref_t;
	// reset values
	localparam scs_ref_t REF_SRC_RESET = SCS_REF_INTERNAL;
	localparam logic HIGH_FREQ_RESET = 1'b1;
	localparam int DIV_W_DEFAULT = 8;
	// power state, one-hot
	typedef enum logic [1:0] {
		SCS_STANDBY = 2'b01,
		SCS_ACTIVE = 2'b10
	} scs_state_t;
endpackage

// ==== include/scs_cmd_if.sv ====
// decoded host command carrier between frame decoder and clock control
`timescale 1ns/1ps
interface scs_cmd_if;
	logic cmd_pulse;
	logic [7:0] cmd_byte;
	logic wake_pulse;
	modport dec (output cmd_pulse, output cmd_byte, output wake_pulse);
	modport ctl (input cmd_pulse, input cmd_byte, input wake_pulse);
endinterface

// ==== verilog/scs_frame_decode.sv ====
// host frame decoder: turns three byte frames into command and wake pulses
`timescale 1ns/1ps
module scs_frame_decode
	import scs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic host_cs_active,
	input wire logic host_byte_valid,
	input wire logic [7:0] host_byte,
	scs_cmd_if.dec cmd
);
	logic [1:0] idx_q;
	logic [1:0] idx_d;
	logic [7:0] first_q;
	logic zero_tail_q;
	logic cmd_pulse_q;
	logic wake_pulse_q;
	logic [7:0] cmd_byte_q;

	// frame position; bytes past the third are data and never decoded
	wire in_frame = host_cs_active && host_byte_valid;
	wire at_first = in_frame && (idx_q == 2'h0);
	wire at_last = in_frame && (idx_q == FRAME_LAST_BYTE);
	wire tail_zero = zero_tail_q && (host_byte == 8'h00);
	wire is_cmd = at_last && tail_zero && (first_q[PREFIX_MSB:PREFIX_LSB] == PREFIX_CMD);
	wire is_wake = at_last && tail_zero && (first_q == 8'h00);
	assign idx_d = !host_cs_active ? 2'h0 : (in_frame && idx_q != 2'h3) ? idx_q + 2'h1 : idx_q;

	// capture frame bytes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			idx_q <= 2'h0;
			first_q <= 8'h00;
			zero_tail_q <= 1'b0;
		end else begin
			idx_q <= idx_d;
			if (at_first) begin
				first_q <= host_byte;
				zero_tail_q <= 1'b1;
			end else if (in_frame && host_byte != 8'h00) begin
				zero_tail_q <= 1'b0;
			end
		end
	end

	// one-cycle decoded pulses
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_pulse_q <= 1'b0;
			wake_pulse_q <= 1'b0;
			cmd_byte_q <= 8'h00;
		end else begin
			cmd_pulse_q <= is_cmd;
			wake_pulse_q <= is_wake;
			if (is_cmd) begin
				cmd_byte_q <= first_q;
			end
		end
	end

	assign cmd.cmd_pulse = cmd_pulse_q;
	assign cmd.wake_pulse = wake_pulse_q;
	assign cmd.cmd_byte = cmd_byte_q;
endmodule

// ==== verilog/scs_clock_ctrl.sv ====
// system clock enable, reference select and vsync-aligned frequency switch
// Contract
// - three reference sources: internal oscillator, 12MHz crystal, 12MHz square wave
// - pll takes the selected reference and clocks all internal engines
// - after reset: standby, internal oscillator selected, system clock off
// - dummy read of address 0 wakes the part and enables the clock
// - 48MHz system clock is the default from a 12MHz reference
// - host commands pick 48MHz or 36MHz; device adopts the request
// - frequency change is applied on a vsync edge, glitch free
// - frequency change only happens while pixel divisor is nonzero
// - external select is 44h, internal select 48h, internal is default
// - 48MHz select is 62h and default, 36MHz select is 61h
// - command frame: bits 0 then 1, six bit code, two zero bytes
// - pixel clock is system clock over divisor; zero disables it
`timescale 1ns/1ps
module scs_clock_ctrl
	import scs_pkg::*;
#(
	parameter int DIV_W = DIV_W_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic host_cs_active,
	input wire logic host_byte_valid,
	input wire logic [7:0] host_byte,
	input wire logic ext_ref_is_square,
	input wire logic [DIV_W-1:0] pclk_divisor,
	input wire logic vsync,
	output logic sysclk_en_q,
	output logic engines_clk_en_q,
	output scs_ref_t ref_src_q,
	output logic pll_high_freq_q,
	output logic freq_change_pending_q,
	output logic pclk_tick_q
);
	// decoded command carrier from the frame decoder
	scs_cmd_if cmd_if ();
	// power state, one-hot
	scs_state_t state_q;
	scs_state_t state_d;
	// clock gates for the pll output and the engines
	logic sysclk_en_d;
	logic engines_clk_en_d;
	// reference select
	scs_ref_t ref_src_d;
	// frequency request, frequency in force and their difference
	logic target_high_q;
	logic target_high_d;
	logic pll_high_freq_d;
	logic freq_change_pending_d;
	// vsync history for the edge detector
	logic vsync_q;
	logic vsync_d;
	// pixel divider
	logic [DIV_W-1:0] pclk_cnt_q;
	logic [DIV_W-1:0] pclk_cnt_d;
	logic pclk_tick_d;

	// true when the decoded frame carries the given command byte
	function automatic logic cmd_is(input logic pulse, input logic [7:0] got, input logic [7:0] code);
		return pulse && (got == code);
	endfunction

	// command bytes arrive on the host link, decoded in their own module
	scs_frame_decode scs_frame_decode_inst (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.host_cs_active(host_cs_active),
		.host_byte_valid(host_byte_valid),
		.host_byte(host_byte),
		.cmd(cmd_if.dec)
	);

	// command decode; reserved codes match none of these and are dropped here
	wire go_ext = cmd_is(cmd_if.cmd_pulse, cmd_if.cmd_byte, SELECT_EXTERNAL_REF_CMD);
	wire go_int = cmd_is(cmd_if.cmd_pulse, cmd_if.cmd_byte, SELECT_INTERNAL_REF_CMD);
	wire go_high = cmd_is(cmd_if.cmd_pulse, cmd_if.cmd_byte, SYSCLK_HIGH_FREQ_CMD);
	wire go_low = cmd_is(cmd_if.cmd_pulse, cmd_if.cmd_byte, SYSCLK_LOW_FREQ_CMD);
	// the crystal and square-wave options share one command; the pin strap tells them apart
	wire scs_ref_t ext_src = ext_ref_is_square ? SCS_REF_SQUARE : SCS_REF_CRYSTAL;

	// power state: standby until the wake read arrives; no way back short of reset
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SCS_STANDBY: begin
				if (cmd_if.wake_pulse) begin
					state_d = SCS_ACTIVE;
				end
			end
			SCS_ACTIVE: begin
				state_d = SCS_ACTIVE;
			end
			// a state word upset off the one-hot codes falls back to standby
			default: begin
				state_d = SCS_STANDBY;
			end
		endcase
	end

	// enables follow the next state so both gates open on the same edge
	assign sysclk_en_d = (state_d == SCS_ACTIVE);
	assign engines_clk_en_d = (state_d == SCS_ACTIVE);
	// a reference command replaces the previous choice; the pll retunes on its own
	assign ref_src_d = go_ext ? ext_src : go_int ? SCS_REF_INTERNAL : ref_src_q;

	// vsync edge and divisor state
	// vsync is taken as synchronous; an asynchronous panel sync would need a synchroniser here
	assign vsync_d = vsync;
	wire div_nonzero = (pclk_divisor != '0);
	wire vsync_edge = vsync && !vsync_q;
	// switching only at a frame edge hides the clock step from the panel
	wire apply_freq = vsync_edge && div_nonzero && (target_high_q != pll_high_freq_q);

	// frequency request, frequency in force and pending flag
	// the newest request wins; the pll keeps its frequency until the apply
	assign target_high_d = go_high ? 1'b1 : go_low ? 1'b0 : target_high_q;
	assign pll_high_freq_d = apply_freq ? target_high_q : pll_high_freq_q;
	// a request landing with the apply edge stays pending, it is not lost
	assign freq_change_pending_d = target_high_d != pll_high_freq_d;

	// pixel tick: one pulse every divisor system clock cycles
	// the counter restarts from zero while stopped, so the first tick comes a full period after start
	wire pclk_run = sysclk_en_q && div_nonzero;
	// >= rather than == so a divisor lowered mid-count wraps at once instead of running to the top
	wire pclk_wrap = pclk_cnt_q >= pclk_divisor - DIV_W'(1);
	assign pclk_cnt_d = (!pclk_run || pclk_wrap) ? '0 : pclk_cnt_q + DIV_W'(1);
	assign pclk_tick_d = pclk_run && pclk_wrap;

	// power state register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= SCS_STANDBY;
		end else begin
			state_q <= state_d;
		end
	end

	// system clock gate
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sysclk_en_q <= 1'b0;
		end else begin
			sysclk_en_q <= sysclk_en_d;
		end
	end

	// engine clock gate
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			engines_clk_en_q <= 1'b0;
		end else begin
			engines_clk_en_q <= engines_clk_en_d;
		end
	end

	// pll reference select
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ref_src_q <= REF_SRC_RESET;
		end else begin
			ref_src_q <= ref_src_d;
		end
	end

	// requested frequency
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			target_high_q <= HIGH_FREQ_RESET;
		end else begin
			target_high_q <= target_high_d;
		end
	end

	// frequency in force
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pll_high_freq_q <= HIGH_FREQ_RESET;
		end else begin
			pll_high_freq_q <= pll_high_freq_d;
		end
	end

	// pending change flag
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			freq_change_pending_q <= 1'b0;
		end else begin
			freq_change_pending_q <= freq_change_pending_d;
		end
	end

	// vsync history; reset level matches the idle pin so no false edge follows reset
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			vsync_q <= 1'b0;
		end else begin
			vsync_q <= vsync_d;
		end
	end

	// pixel divider count
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pclk_cnt_q <= '0;
		end else begin
			pclk_cnt_q <= pclk_cnt_d;
		end
	end

	// pixel tick
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pclk_tick_q <= 1'b0;
		end else begin
			pclk_tick_q <= pclk_tick_d;
		end
	end
endmodule

// ==== tb/scs_host_model.sv ====
// host model sending three byte frames over the byte link
`timescale 1ns/1ps
module scs_host_model (
	input wire logic ref_clk,
	output logic host_cs_active,
	output logic host_byte_valid,
	output logic [7:0] host_byte
);
	// byte-level link, so serial clock limits stay outside this model
	// oscillator trim is register traffic outside this block; no trim frames are sent
	initial begin
		host_cs_active = 1'b0;
		host_byte_valid = 1'b0;
		host_byte = 8'h5a;
	end
	// select drops between frames; idle byte is inverted so no stale value lingers
	task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		logic [23:0] f;
		f = {b0, b1, b2};
		@(posedge ref_clk) host_cs_active <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk) host_byte_valid <= 1'b1;
			host_byte <= f[23-8*i -: 8];
			@(posedge ref_clk) host_byte_valid <= 1'b0;
			host_byte <= ~f[23-8*i -: 8];
		end
		@(posedge ref_clk) host_cs_active <= 1'b0;
	endtask
endmodule

// ==== tb/scs_clock_ctrl_checker.sv ====
// assertion checker for the system clock control block
`timescale 1ns/1ps
module scs_clock_ctrl_checker
	import scs_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic host_cs_active,
	input wire logic host_byte_valid,
	input wire logic [7:0] host_byte,
	input wire logic ext_ref_is_square,
	input wire logic [DIV_W-1:0] pclk_divisor,
	input wire logic vsync,
	input wire logic sysclk_en_q,
	input wire logic engines_clk_en_q,
	input wire scs_ref_t ref_src_q,
	input wire logic pll_high_freq_q,
	input wire logic freq_change_pending_q,
	input wire logic pclk_tick_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	AST_ENG: assert property (engines_clk_en_q == sysclk_en_q) else $error("engine gate differs");
	AST_EN_HOLD: assert property (sysclk_en_q |=> sysclk_en_q) else $error("clock enable dropped");
	AST_WAKE: assert property ($rose(sysclk_en_q) |->
		$past(host_byte_valid, 2) && $past(host_byte, 2) == 8'h00) else $error("enable without wake frame");
	AST_PEND: assert property ($changed(pll_high_freq_q) |-> $past(freq_change_pending_q))
		else $error("frequency moved unrequested");
	AST_VS: assert property ($changed(pll_high_freq_q) |-> $past(vsync) && !$past(vsync, 2))
		else $error("switch off vsync edge");
	AST_DIV: assert property ($changed(pll_high_freq_q) |-> $past(pclk_divisor) != 0)
		else $error("switch with divisor 0");
	AST_TOFF: assert property ((pclk_divisor == 0)[*2] |-> !pclk_tick_q) else $error("tick with divisor 0");
	AST_TPER: assert property (pclk_tick_q && pclk_divisor == 3 |=>
		!pclk_tick_q ##1 !pclk_tick_q ##1 pclk_tick_q) else $error("tick spacing wrong");
	AST_REF: assert property ($changed(ref_src_q) |->
		$past(host_byte_valid, 2) && $past(host_byte, 2) == 8'h00) else $error("reference moved off frame");
endmodule
bind scs_clock_ctrl scs_clock_ctrl_checker #(.DIV_W(DIV_W)) scs_clock_ctrl_checker_inst (.*);

// ==== tb/tb_scs_clock_ctrl.sv ====
// self-checking bench for the system clock control block
`timescale 1ns/1ps
module tb_scs_clock_ctrl;
	import scs_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic ext_ref_is_square = 1'b0;
	logic [7:0] pclk_divisor = 8'h00;
	logic vsync = 1'b0;
	logic host_cs_active, host_byte_valid, sysclk_en_q, engines_clk_en_q, pll_high_freq_q, freq_change_pending_q;
	logic pclk_tick_q;
	logic [7:0] host_byte;
	scs_ref_t ref_src_q;
	logic [31:0] seed = 32'hd816;
	logic hf = 1'b0;
	logic [7:0] k;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	initial forever #2 ref_clk = ~ref_clk;
	scs_host_model scs_host_model_inst (.ref_clk, .host_cs_active, .host_byte_valid, .host_byte);
	scs_clock_ctrl scs_clock_ctrl_inst (.ref_clk, .rstn, .host_cs_active, .host_byte_valid, .host_byte,
		.ext_ref_is_square, .pclk_divisor, .vsync, .sysclk_en_q, .engines_clk_en_q, .ref_src_q,
		.pll_high_freq_q, .freq_change_pending_q, .pclk_tick_q);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [7:0] exp_ref(input logic int_sel, input logic sq);
		return int_sel ? SCS_REF_INTERNAL : (sq ? SCS_REF_SQUARE : SCS_REF_CRYSTAL);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// count pixel ticks seen over c cycles
	task automatic ticks(input int c, output logic [7:0] cnt);
		cnt = 8'h00;
		repeat (c) begin
			w(1);
			cnt += {7'h00, pclk_tick_q};
		end
	endtask
	// vsync held high a few cycles so the rising edge is seen
	task automatic vs();
		@(posedge ref_clk) vsync <= 1'b1;
		repeat (3) @(posedge ref_clk);
		vsync <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, far above the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// main sequence: a frequency request in standby, then wake, reference select, then divisor, the last three as the host must order them
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		w(1);
		check({sysclk_en_q, ref_src_q, pll_high_freq_q}, 4'b0001);
		scs_host_model_inst.send(SYSCLK_LOW_FREQ_CMD, 8'h00, 8'h00);
		vs();
		w(2);
		check({pll_high_freq_q, freq_change_pending_q}, 2'b11);
		scs_host_model_inst.send(8'h00, 8'h00, 8'h00);
		w(3);
		check({sysclk_en_q, engines_clk_en_q}, 2'b11);
		ticks(6, k);
		check(k, 8'h00);
		$display("test done: reset and wake");
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			@(posedge ref_clk) ext_ref_is_square <= seed[0];
			scs_host_model_inst.send(i[0] ? SELECT_INTERNAL_REF_CMD : SELECT_EXTERNAL_REF_CMD, 8'h00, 8'h00);
			w(3);
			check(ref_src_q, exp_ref(i[0], seed[0]));
		end
		$display("test done: reference select");
		@(posedge ref_clk) pclk_divisor <= 8'h03;
		vs();
		w(1);
		check({pll_high_freq_q, freq_change_pending_q}, 2'b00);
		scs_host_model_inst.send(SYSCLK_HIGH_FREQ_CMD, 8'h01, 8'h00);
		w(3);
		check(freq_change_pending_q, 1'b0);
		ticks(12, k);
		check(k, 8'h04);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			scs_host_model_inst.send(seed[1] ? SYSCLK_HIGH_FREQ_CMD : SYSCLK_LOW_FREQ_CMD, 8'h00, 8'h00);
			w(3);
			check(freq_change_pending_q, seed[1] != hf);
			vs();
			w(1);
			hf = seed[1];
			check({pll_high_freq_q, freq_change_pending_q}, {hf, 1'b0});
		end
		$display("test done: frequency switching");
		report_and_stop();
	end
endmodule
